// ### iplc_pkg.sv
// constants, register map and carrier types of the input power limit control
// assumes a 50 MHz system clock and millivolt / 10 mA codes from the analog side
package iplc_pkg;

   // ==========================================================================
   // clock and timing
   localparam int CLK_HZ = 50000000;
   localparam int CLK_MHZ = CLK_HZ / 1000000;
   // least dwell between two optimizer current steps, in ns
   localparam int OPT_STEP_NS = 10000;
   localparam int OPT_STEP_CYC = (OPT_STEP_NS * CLK_MHZ + 999) / 1000;

   // ==========================================================================
   // register offsets (byte addresses)
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_ICL = 5'h04;
   localparam logic [4:0] OFS_VDL = 5'h08;
   localparam logic [4:0] OFS_STAT = 5'h0C;
   localparam logic [4:0] OFS_FLAG = 5'h10;
   localparam logic [4:0] OFS_EFF = 5'h14;
   localparam logic [4:0] OFS_CLAMP = 5'h18;

   // control register fields
   localparam int CTRL_W = 7;
   localparam int B_OPT_EN = 0;
   localparam int B_OPT_FORCE = 1;
   localparam int B_HIZ = 2;
   localparam int B_EXT_CLAMP = 3;
   localparam int B_REMEAS = 4;
   localparam int B_PFM_DIS = 5;
   localparam int B_AUDIO_DIS = 6;
   localparam logic [6:0] CTRL_RST = 7'h08;

   // status register fields
   localparam int B_OPT_ST_LO = 0;
   localparam int B_MINSYS = 2;
   localparam int B_VDL_ACT = 3;
   localparam int B_ICL_ACT = 4;
   // flag register field
   localparam int B_OPT_FLAG = 0;

   // optimizer state codes
   localparam logic [1:0] OPT_OFF = 2'h0;
   localparam logic [1:0] OPT_RUN = 2'h1;
   localparam logic [1:0] OPT_DONE = 2'h2;

   // ==========================================================================
   // current codes, 10 mA per step
   localparam int CUR_W = 9;
   localparam logic [8:0] CUR_MIN = 9'h00A;
   localparam logic [8:0] CUR_OPT_START = 9'h032;
   localparam logic [8:0] CUR_DEFAULT = 9'h12C;
   localparam logic [8:0] CUR_MAX = 9'h14A;
   localparam logic [8:0] CUR_STEP = 9'h00A;

   // voltages in mV
   localparam int MV_W = 16;
   localparam logic [15:0] VDL_MIN = 16'h0E10;
   localparam logic [15:0] VDL_MAX = 16'h55F0;
   localparam logic [15:0] VDL_RST = 16'h0E10;
   localparam logic [15:0] VBUS_HI_THR = 16'h1B58;
   localparam logic [15:0] VBUS_OFS_HI = 16'h0578;
   localparam logic [15:0] VBUS_OFS_LO = 16'h02BC;
   localparam logic [15:0] PIN_BASE = 16'h03E8;
   localparam logic [15:0] PIN_FLOOR = 16'h0438;
   // 800 mohm: 8 mV per 10 mA code
   localparam int PIN_MV_SHIFT = 3;

   // adc channels and bus answers
   localparam logic ADC_CH_VBUS = 1'b0;
   localparam logic ADC_CH_PIN = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic adapter_present;
      logic dcp_detected;
      logic vbat_below_sysmin;
      logic sys_at_min;
      logic vdl_loop;
      logic icl_loop;
      logic input_overvoltage;
      logic vsys_ovp;
      logic vbat_ovp;
      logic sys_short;
      logic input_overcurrent;
      logic pin_below_low;
      logic pin_above_high;
   } iplc_sense_t;

   typedef struct packed {
      logic gate_reg_on;
      logic switching_on;
      logic adc_on;
      logic batt_switch_on;
      logic charge_suspend;
      logic pfm_on;
      logic audio_floor_on;
   } iplc_drive_t;

endpackage : iplc_pkg

// ### iplc_core.sv
// input power limit control: optimizer, voltage limit derivation, hiz, limit pin clamp
// assumes asynchronous comparator levels, a same-clock adc, and an AXI4-Lite master
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
module iplc_core
   import iplc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [iplc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [iplc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire iplc_pkg::iplc_sense_t SENSE,
   output logic ADC_REQ,
   output logic ADC_CH,
   input wire logic ADC_VALID,
   input wire logic [iplc_pkg::MV_W-1:0] ADC_MV,
   output iplc_pkg::iplc_drive_t DRIVE,
   output logic [iplc_pkg::CUR_W-1:0] PIN_CURRENT_CLAMP_CODE
);
   import iplc_pkg::*;

   // ==========================================================================
   // helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic [CUR_W-1:0] min_cur(input logic [CUR_W-1:0] a,
                                               input logic [CUR_W-1:0] b);
      return (a < b) ? a : b;
   endfunction : min_cur

   // pin voltage to current code: v = 1 V + 0.8 ohm * i
   function automatic logic [CUR_W-1:0] pin_to_clamp(input logic [MV_W-1:0] mv);
      logic [MV_W-1:0] q;
      q = (mv - PIN_BASE) >> PIN_MV_SHIFT;
      if (mv < PIN_FLOOR) begin
         return CUR_MIN;
      end
      if (q > MV_W'(CUR_MAX)) begin
         return CUR_MAX;
      end
      return q[CUR_W-1:0];
   endfunction : pin_to_clamp

   function automatic logic [MV_W-1:0] vbus_to_vdl(input logic [MV_W-1:0] mv);
      logic [MV_W:0] v;
      v = (mv >= VBUS_HI_THR) ? ({1'b0, mv} - {1'b0, VBUS_OFS_HI})
                              : ({1'b0, mv} - {1'b0, VBUS_OFS_LO});
      if (v[MV_W] || v[MV_W-1:0] < VDL_MIN) begin
         return VDL_MIN;
      end
      if (v[MV_W-1:0] > VDL_MAX) begin
         return VDL_MAX;
      end
      return v[MV_W-1:0];
   endfunction : vbus_to_vdl

   // ==========================================================================
   // input synchronisers: a change counts once stages two and three agree
   iplc_sense_t sync1_r, sync2_r, sync3_r, sense_r, sense_prev_r;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= SENSE;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sense_r <= '0;
         sense_prev_r <= '0;
      end else begin
         sense_r <= (sync2_r & sync3_r) | (sense_r & (sync2_r | sync3_r));
         sense_prev_r <= sense_r;
      end
   end

   wire adapter_rise = sense_r.adapter_present & ~sense_prev_r.adapter_present;
   wire dcp_rise = sense_r.dcp_detected & ~sense_prev_r.dcp_detected;
   wire ovp_rise = sense_r.input_overvoltage & ~sense_prev_r.input_overvoltage;
   wire hiz_fault = (sense_r.sys_short & ~sense_prev_r.sys_short)
                  | (sense_r.input_overcurrent & ~sense_prev_r.input_overcurrent);
   wire ovp_any = sense_r.input_overvoltage | sense_r.vsys_ovp | sense_r.vbat_ovp;

   // ==========================================================================
   // AXI4-Lite slave handshake
   logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;

   assign S_AXI_AWREADY = ~aw_got_r & ~bvalid_r;
   assign S_AXI_WREADY = ~w_got_r & ~bvalid_r;
   assign S_AXI_ARREADY = ~rvalid_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;

   wire wr_go = aw_got_r & w_got_r & ~bvalid_r;
   wire rd_go = S_AXI_ARVALID & ~rvalid_r;
   wire [ADDR_W-1:0] wa = {awaddr_r[ADDR_W-1:2], 2'b00};
   wire [ADDR_W-1:0] ra = {S_AXI_ARADDR[ADDR_W-1:2], 2'b00};
   wire wr_ctrl = wr_go & (wa == OFS_CTRL);
   wire wr_icl = wr_go & (wa == OFS_ICL);
   wire wr_vdl = wr_go & (wa == OFS_VDL);
   wire wr_flag = wr_go & (wa == OFS_FLAG);
   wire wa_ok = (wa <= OFS_CLAMP);
   wire ra_ok = (ra <= OFS_CLAMP);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID & S_AXI_AWREADY) begin
            aw_got_r <= 1'b1;
            awaddr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & S_AXI_WREADY) begin
            w_got_r <= 1'b1;
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wa_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r & S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // register state
   typedef enum logic [2:0] {PU_IDLE, PU_PIN, PU_BUS, PU_RUN, PU_REMEAS} iplc_pu_t;
   iplc_pu_t pu_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [CUR_W-1:0] icl_r, clamp_r, opt_pin_current_clamp_r, eff_r;
   logic [MV_W-1:0] vdl_r;
   logic [1:0] opt_state_r, opt_state_prev_r;
   logic opt_flag_r, pin_stop_r, restart_r;
   logic [15:0] step_cnt_r;

   wire opt_en = ctrl_r[B_OPT_EN];
   wire hiz = ctrl_r[B_HIZ];
   wire ext_en = ctrl_r[B_EXT_CLAMP];
   wire remeas = ctrl_r[B_REMEAS];
   wire adc_done = ADC_REQ & ADC_VALID;

   wire [31:0] ctrl_wr = merge({25'h0, ctrl_r}, wdata_r, wstrb_r);
   wire [31:0] icl_wr = merge({23'h0, icl_r}, wdata_r, wstrb_r);
   wire [31:0] vdl_wr = merge({16'h0, vdl_r}, wdata_r, wstrb_r);
   wire icl_wr_ok = (icl_wr[31:CUR_W] == '0) & ~(ext_en & (icl_wr[CUR_W-1:0] > clamp_r));
   wire force_evt = wr_ctrl & ctrl_wr[B_OPT_FORCE];
   wire remeas_skip = (pu_r == PU_RUN) & remeas & sense_r.sys_at_min;
   wire remeas_done = (pu_r == PU_REMEAS) & adc_done;

   // ==========================================================================
   // control register: hardware sets of hiz win over software and plug clears
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl_r <= CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_wr[CTRL_W-1:0];
         end else begin
            ctrl_r[B_OPT_FORCE] <= 1'b0;
            if (remeas_skip | remeas_done) begin
               ctrl_r[B_REMEAS] <= 1'b0;
            end
         end
         if (adapter_rise) begin
            ctrl_r[B_HIZ] <= 1'b0;
         end
         if (hiz_fault) begin
            ctrl_r[B_HIZ] <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // power-up and remeasure sequence
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pu_r <= PU_IDLE;
         clamp_r <= CUR_MAX;
         icl_r <= CUR_DEFAULT;
         vdl_r <= VDL_RST;
      end else begin
         if (wr_icl & icl_wr_ok) begin
            icl_r <= icl_wr[CUR_W-1:0];
         end
         if (wr_vdl) begin
            vdl_r <= vdl_wr[MV_W-1:0];
         end
         if (~sense_r.adapter_present | hiz) begin
            pu_r <= PU_IDLE;
         end else begin
            case (pu_r)
               PU_IDLE: begin
                  pu_r <= PU_PIN;
               end
               PU_PIN: begin
                  if (adc_done) begin
                     clamp_r <= pin_to_clamp(ADC_MV);
                     icl_r <= (ext_en & (CUR_DEFAULT > pin_to_clamp(ADC_MV)))
                              ? pin_to_clamp(ADC_MV) : CUR_DEFAULT;
                     pu_r <= PU_BUS;
                  end
               end
               PU_BUS: begin
                  if (adc_done) begin
                     vdl_r <= vbus_to_vdl(ADC_MV);
                     pu_r <= PU_RUN;
                  end
               end
               PU_RUN: begin
                  if (remeas & ~sense_r.sys_at_min) begin
                     pu_r <= PU_REMEAS;
                  end
               end
               PU_REMEAS: begin
                  if (adc_done) begin
                     vdl_r <= vbus_to_vdl(ADC_MV);
                     pu_r <= PU_RUN;
                  end
               end
               default: begin
                  pu_r <= PU_IDLE;
               end
            endcase
         end
      end
   end

   assign ADC_REQ = ~hiz & ((pu_r == PU_PIN) | (pu_r == PU_BUS) | (pu_r == PU_REMEAS));
   assign ADC_CH = (pu_r == PU_PIN) ? ADC_CH_PIN : ADC_CH_VBUS;

   // ==========================================================================
   // optimizer
   logic [CUR_W-1:0] icl_prev_r;
   logic [MV_W-1:0] vdl_prev_r;
   logic hiz_prev_r;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         icl_prev_r <= CUR_DEFAULT;
         vdl_prev_r <= VDL_RST;
         hiz_prev_r <= 1'b0;
         restart_r <= 1'b0;
      end else begin
         icl_prev_r <= icl_r;
         vdl_prev_r <= vdl_r;
         hiz_prev_r <= hiz;
         restart_r <= adapter_rise | (hiz != hiz_prev_r) | (icl_r != icl_prev_r)
                    | (vdl_r != vdl_prev_r) | force_evt | ovp_rise;
      end
   end

   wire opt_start = restart_r | dcp_rise;
   wire step_due = (step_cnt_r == 16'(OPT_STEP_CYC - 1));

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         opt_state_r <= OPT_OFF;
         opt_pin_current_clamp_r <= CUR_OPT_START;
         step_cnt_r <= '0;
      end else if (~opt_en) begin
         opt_state_r <= OPT_OFF;
         step_cnt_r <= '0;
      end else if (opt_start) begin
         opt_state_r <= OPT_RUN;
         opt_pin_current_clamp_r <= sense_r.vbat_below_sysmin ? icl_r : CUR_OPT_START;
         step_cnt_r <= '0;
      end else if (opt_state_r == OPT_RUN) begin
         if (sense_r.vdl_loop) begin
            opt_state_r <= OPT_DONE;
         end else if (step_due) begin
            step_cnt_r <= '0;
            if (opt_pin_current_clamp_r >= icl_r) begin
               opt_state_r <= OPT_DONE;
            end else begin
               opt_pin_current_clamp_r <= min_cur(opt_pin_current_clamp_r + CUR_STEP, icl_r);
            end
         end else begin
            step_cnt_r <= step_cnt_r + 16'h0001;
         end
      end
   end

   // flag: a state change in the clearing cycle keeps it set
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         opt_state_prev_r <= OPT_OFF;
         opt_flag_r <= 1'b0;
      end else begin
         opt_state_prev_r <= opt_state_r;
         opt_flag_r <= (opt_state_r != opt_state_prev_r)
                     | (opt_flag_r & ~(wr_flag & wdata_r[B_OPT_FLAG] & wstrb_r[0]));
      end
   end

   // ==========================================================================
   // effective limit, pin hysteresis and power outputs
   wire [CUR_W-1:0] lim_src = opt_en ? opt_pin_current_clamp_r : icl_r;
   wire pin_stop_nxt = sense_r.pin_below_low ? 1'b1
                     : (sense_r.pin_above_high ? 1'b0 : pin_stop_r);
   wire sw_ok = (pu_r == PU_RUN) & ~hiz & ~ovp_any & ~pin_stop_r;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         eff_r <= CUR_DEFAULT;
         pin_stop_r <= 1'b0;
         DRIVE <= '0;
      end else begin
         eff_r <= (ext_en & (lim_src > clamp_r)) ? clamp_r : lim_src;
         pin_stop_r <= pin_stop_nxt;
         DRIVE.gate_reg_on <= sense_r.adapter_present & ~hiz;
         DRIVE.switching_on <= sw_ok;
         DRIVE.adc_on <= ~hiz;
         DRIVE.batt_switch_on <= hiz | ~sw_ok;
         DRIVE.charge_suspend <= ~sw_ok;
         DRIVE.pfm_on <= ~ctrl_r[B_PFM_DIS];
         DRIVE.audio_floor_on <= ~ctrl_r[B_PFM_DIS] & ~ctrl_r[B_AUDIO_DIS];
      end
   end

   assign PIN_CURRENT_CLAMP_CODE = eff_r;

   // ==========================================================================
   // read path
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (ra)
         OFS_CTRL: rd_word = {25'h0, ctrl_r};
         OFS_ICL: rd_word = {23'h0, icl_r};
         OFS_VDL: rd_word = {16'h0, vdl_r};
         OFS_STAT: rd_word = {27'h0, sense_r.icl_loop, sense_r.vdl_loop,
                              sense_r.sys_at_min, opt_state_r};
         OFS_FLAG: rd_word = {31'h0, opt_flag_r};
         OFS_EFF: rd_word = {23'h0, eff_r};
         OFS_CLAMP: rd_word = {23'h0, clamp_r};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= ra_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r & S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule : iplc_core

// ### iplc_chk.sv
// checker: bus, adc and drive relations of the input power limit control
// assumes it is bound into iplc_core and sees only its ports
module iplc_chk
   import iplc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [iplc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire iplc_pkg::iplc_sense_t SENSE,
   input wire logic ADC_REQ,
   input wire iplc_pkg::iplc_drive_t DRIVE,
   input wire logic [iplc_pkg::CUR_W-1:0] PIN_CURRENT_CLAMP_CODE
);
   // ====
   // properties
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
   property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_unmap; S_AXI_ARVALID && S_AXI_ARREADY
      && {S_AXI_ARADDR[ADDR_W-1:2], 2'b00} > OFS_CLAMP
      |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read answered");
   property p_lim; PIN_CURRENT_CLAMP_CODE >= CUR_MIN && PIN_CURRENT_CLAMP_CODE <= CUR_MAX; endproperty
   a_lim: assert property (p_lim) else $error("limit code out of range");
   property p_meas; ADC_REQ |=> !DRIVE.switching_on; endproperty
   a_meas: assert property (p_meas) else $error("switching while measuring");
   property p_bat; !$past(SYS_RST) && !DRIVE.switching_on |-> DRIVE.batt_switch_on;
   endproperty
   a_bat: assert property (p_bat) else $error("battery switch off while idle");
   property p_ovp; SENSE.input_overvoltage [*8] |-> !DRIVE.switching_on; endproperty
   a_ovp: assert property (p_ovp) else $error("switching during overvoltage");
   property p_pin; SENSE.pin_below_low [*8] |-> !DRIVE.switching_on; endproperty
   a_pin: assert property (p_pin) else $error("switching with pin low");
   property p_aud; DRIVE.audio_floor_on |-> DRIVE.pfm_on; endproperty
   a_aud: assert property (p_aud) else $error("audio floor without pfm");
   c_unmap: cover property (S_AXI_ARVALID && S_AXI_ARREADY
      && {S_AXI_ARADDR[ADDR_W-1:2], 2'b00} > OFS_CLAMP);
   c_ovp: cover property (SENSE.input_overvoltage [*8]);
   c_meas: cover property ($rose(ADC_REQ));
endmodule : iplc_chk

bind iplc_core iplc_chk iplc_chk_i (.CLK, .SYS_RST, .S_AXI_BRESP, .S_AXI_BVALID,
   .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
   .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .SENSE, .ADC_REQ, .DRIVE, .PIN_CURRENT_CLAMP_CODE);

// ### iplc_adc_model.sv
// adc partner: answers a held request after a set delay with the chosen channel
// assumes the clock and reset of iplc_core
module iplc_adc_model
   import iplc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic ch,
   input wire logic [15:0] pin_mv,
   input wire logic [15:0] vbus_mv,
   input wire logic [3:0] dly,
   output logic valid,
   output logic [15:0] mv
);
   logic [3:0] cnt_r;
   // ====
   // result flips every cycle outside its one valid cycle
   always_ff @(posedge clk) begin
      valid <= 1'b0;
      mv <= rst ? 16'hA5A5 : ~mv;
      if (rst || !req || valid) begin
         cnt_r <= dly;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end else begin
         valid <= 1'b1;
         mv <= (ch == ADC_CH_PIN) ? pin_mv : vbus_mv;
      end
   end
endmodule : iplc_adc_model

// ### input_power_limit_control_tb.sv
// self-checking bench for iplc_core with the adc partner model
// assumes iplc_pkg, iplc_core and iplc_adc_model are compiled first
module input_power_limit_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import iplc_pkg::*;
   localparam logic [15:0] VB[3] = '{16'h61A8, 16'h0FA0, 16'h1388};
   localparam logic [15:0] VL[3] = '{16'h55F0, 16'h0E10, 16'h10CC};
   localparam logic [6:0] PF[3] = '{7'h01, 7'h21, 7'h41};
   localparam logic [1:0] PE[3] = '{2'b11, 2'b00, 2'b10};
   localparam int FB[2] = '{6, 1};
   logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
   logic S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID, ADC_REQ, ADC_CH, ADC_VALID;
   logic [4:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic [15:0] ADC_MV, pin_mv, vbus_mv;
   logic [3:0] dly;
   logic [8:0] PIN_CURRENT_CLAMP_CODE, v;
   logic [38:0] e;
   iplc_sense_t SENSE;
   iplc_drive_t DRIVE;
   logic [38:0] exp_q[$];
   int errors, num_checks, i;

   iplc_core iplc_core_i (.CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
      .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .SENSE, .ADC_REQ,
      .ADC_CH, .ADC_VALID, .ADC_MV, .DRIVE, .PIN_CURRENT_CLAMP_CODE);
   iplc_adc_model iplc_adc_model_i (.clk(CLK), .rst(SYS_RST), .req(ADC_REQ), .ch(ADC_CH),
      .pin_mv, .vbus_mv, .dly, .valid(ADC_VALID), .mv(ADC_MV));

   always #10 CLK = ~CLK;

   task automatic chk(input string n, input logic [33:0] x, input logic [33:0] s);
      num_checks++;
      if (x !== s) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, x, s);
      end
   endtask : chk

   // ====
   // bus answers compared against the oldest expected note
   always @(posedge CLK) begin
      if ((S_AXI_RVALID && S_AXI_RREADY) || (S_AXI_BVALID && S_AXI_BREADY)) begin
         e = exp_q.pop_front();
         chk($sformatf("reg %h", e[38:34]), e[33:0],
            S_AXI_RVALID ? {S_AXI_RRESP, S_AXI_RDATA} : {S_AXI_BRESP, 32'h0});
      end
   end

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      exp_q.push_back({a, RESP_OKAY, 32'h0});
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      S_AXI_BREADY <= 1'b0;
      @(posedge CLK);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [33:0] x);
      exp_q.push_back({a, x});
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      S_AXI_RREADY <= 1'b0;
      @(posedge CLK);
   endtask : rd

   task automatic wait_sw(input logic w);
      i = 0;
      while (DRIVE.switching_on !== w && i < 3000) begin
         @(posedge CLK);
         i++;
      end
      chk("switching", 34'(w), 34'(DRIVE.switching_on));
   endtask : wait_sw

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (40000) @(posedge CLK);
      errors++;
      close_out();
   end

   // ====
   // tests
   initial begin
      {CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 5'h08;
      {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
      SENSE = '0;
      SENSE.pin_above_high = 1'b1;
      pin_mv = 16'h0A28;
      vbus_mv = 16'h2328;
      i = $urandom(32'h1531);
      dly = 4'($urandom);
      repeat (4) @(posedge CLK);
      SYS_RST <= 1'b0;
      @(posedge CLK);
      rd(OFS_CTRL, 34'h08);
      rd(OFS_ICL, 34'h12C);
      rd(OFS_VDL, 34'hE10);
      rd(OFS_STAT, 34'h0);
      rd(5'h1C, {RESP_SLVERR, 32'h0});
      $display("done: reset values");
      SENSE.adapter_present <= 1'b1;
      wait_sw(1'b1);
      rd(OFS_CLAMP, 34'hC8);
      rd(OFS_ICL, 34'hC8);
      rd(OFS_VDL, 34'h1DB0);
      wr(OFS_ICL, 32'hFA);
      rd(OFS_ICL, 34'hC8);
      wr(OFS_CTRL, 32'h0);
      v = 9'(101 + $urandom % 200);
      wr(OFS_ICL, {23'h0, v});
      rd(OFS_EFF, {25'h0, v});
      chk("limit code", 34'(v), 34'(PIN_CURRENT_CLAMP_CODE));
      $display("done: power up and clamp");
      foreach (VB[k]) begin
         vbus_mv <= VB[k];
         dly <= 4'($urandom);
         wr(OFS_CTRL, 32'h10); // remeasure request, clamp and optimizer off
         wait_sw(1'b0);
         wait_sw(1'b1);
         rd(OFS_CTRL, 34'h0);
         rd(OFS_VDL, {18'h0, VL[k]});
      end
      {SENSE.sys_at_min, SENSE.vdl_loop, SENSE.icl_loop} <= 3'b111;
      repeat (8) @(posedge CLK);
      rd(OFS_STAT, 34'h1C);
      wr(OFS_CTRL, 32'h10);
      repeat (8) @(posedge CLK);
      rd(OFS_CTRL, 34'h0);
      rd(OFS_VDL, 34'h10CC);
      {SENSE.sys_at_min, SENSE.vdl_loop, SENSE.icl_loop, SENSE.dcp_detected} <= 4'h1;
      repeat (8) @(posedge CLK);
      $display("done: remeasure");
      rd(OFS_STAT, 34'h0);
      SENSE.dcp_detected <= 1'b0;
      repeat (8) @(posedge CLK);
      wr(OFS_CTRL, 32'h1);
      SENSE.dcp_detected <= 1'b1;
      repeat (8) @(posedge CLK);
      rd(OFS_STAT, 34'h1);
      rd(OFS_EFF, 34'h32);
      SENSE.vdl_loop <= 1'b1;
      repeat (8) @(posedge CLK);
      rd(OFS_STAT, 34'hA);
      rd(OFS_FLAG, 34'h1);
      wr(OFS_FLAG, 32'h1);
      rd(OFS_FLAG, 34'h0);
      SENSE.vdl_loop <= 1'b0;
      repeat (8) @(posedge CLK);
      wr(OFS_ICL, 32'h64);
      rd(OFS_STAT, 34'h1);
      SENSE.vbat_below_sysmin <= 1'b1;
      repeat (8) @(posedge CLK);
      wr(OFS_CTRL, 32'h3);
      rd(OFS_CTRL, 34'h1);
      rd(OFS_EFF, 34'h64);
      $display("done: optimizer");
      foreach (PF[k]) begin
         wr(OFS_CTRL, {25'h0, PF[k]});
         repeat (2) @(posedge CLK);
         chk("pfm", 34'(PE[k]), 34'({DRIVE.pfm_on, DRIVE.audio_floor_on}));
      end
      foreach (FB[k]) begin
         SENSE[FB[k]] <= 1'b1;
         SENSE.pin_above_high <= (FB[k] != 1);
         repeat (10) @(posedge CLK);
         chk("fault", 34'h1, 34'({DRIVE.switching_on, DRIVE.gate_reg_on}));
         SENSE[FB[k]] <= 1'b0;
         SENSE.pin_above_high <= 1'b1;
         wait_sw(1'b1);
      end
      $display("done: modes and faults");
      wr(OFS_CTRL, 32'h4);
      repeat (4) @(posedge CLK);
      chk("hiz", 34'h3, 34'({DRIVE.gate_reg_on, DRIVE.switching_on, DRIVE.adc_on,
         DRIVE.batt_switch_on, DRIVE.charge_suspend}));
      pin_mv <= 16'h0410;
      SENSE.adapter_present <= 1'b0;
      repeat (8) @(posedge CLK);
      SENSE.adapter_present <= 1'b1;
      wait_sw(1'b1);
      rd(OFS_CTRL, 34'h0);
      rd(OFS_CLAMP, 34'hA);
      SENSE.sys_short <= 1'b1;
      repeat (8) @(posedge CLK);
      rd(OFS_CTRL, 34'h4);
      $display("done: high impedance");
      close_out();
   end
endmodule : input_power_limit_control_tb
